//--- design/dual_shift_cfg.svh
/*
  Constants for the dual serial shift register: stage count, pin
  group width and reset values.
  Assumes inclusion by the package and the design module only.
*/
// What this block does
// - Two eight-stage registers, common plus separate clocks
// - Shift clock is common OR separate clock
// - All stages shift together on one event
// - Serial input captured at combined clock rise
// - Either clock held high freezes contents
// - Falling combined clock never changes outputs
// - Select low takes first input, high second
// - Input bit reaches last stage after eight pulses
// - Clear low empties all sixteen stages asynchronously
`ifndef DUAL_SHIFT_CFG_SVH
`define DUAL_SHIFT_CFG_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define NUM_STAGES   8
`define NUM_REGS     2
`define PIN_W        8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define STAGE_RESET  8'h00
`define PIN_RESET    8'h00
`define CLK_RESET    2'h0
`define CLR_SYNC_RESET 2'h0

`endif

//--- design/dual_shift_pkg.sv
/*
  Types shared by the dual serial shift register.
  Assumes the constants header sits beside it.
*/
`include "dual_shift_cfg.svh"

package dual_shift_pkg;

  // ----------------------------------------------------------------
  // Pin group sampled from outside the mclk domain
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       shift_pulse_common;
    logic [1:0] shift_pulse_sep;
    logic       select;
    logic [1:0] serial_in_first;
    logic [1:0] serial_in_second;
  } pin_in_t;

  typedef logic [`NUM_STAGES-1:0] stage_t;
  typedef logic [`PIN_W-1:0]      pin_vec_t;

endpackage

//--- design/dual_serial_shift_register.sv
/*
  Two eight-stage serial shift registers with input selectors, combined
  clocks and a shared asynchronous clear, modelled on the mclk domain.
  Assumes all pin inputs are asynchronous to mclk and that each pin level
  is held for well over three mclk periods.
*/
`timescale 1ns/1ps
`include "dual_shift_cfg.svh"

module dual_serial_shift_register (
  input  wire logic                    mclk,
  input  wire logic                    rstn,
  input  wire dual_shift_pkg::pin_in_t pins,
  input  wire logic                    clear_all_n,
  output logic [`NUM_REGS-1:0]         last_stage_out,
  output logic [`NUM_REGS-1:0]         last_stage_out_inv
);
  import dual_shift_pkg::*;

  // Stage clear, low from rstn or the clear pin; released through two flops
  logic clr_n;

  // ----------------------------------------------------------------
  // Assertion defaults
  // ----------------------------------------------------------------
  // Checks pause while the stages are held clear
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!clr_n);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic pick_bit(input logic sel,
                                    input logic first,
                                    input logic second);
    pick_bit = sel ? second : first;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchroniser: three flops, a level counts once 2nd and 3rd agree
  // ----------------------------------------------------------------
  pin_vec_t sync1;
  pin_vec_t sync2;
  pin_vec_t sync3;
  pin_in_t  filt;
  pin_in_t  next_filt;
  pin_vec_t agree;

  always_comb begin
    agree     = ~(sync2 ^ sync3);
    next_filt = pin_in_t'((sync2 & agree) | (pin_vec_t'(filt) & ~agree));
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sync1 <= `PIN_RESET;
      sync2 <= `PIN_RESET;
      sync3 <= `PIN_RESET;
      filt  <= pin_in_t'(`PIN_RESET);
    end else begin
      sync1 <= pin_vec_t'(pins);
      sync2 <= sync1;
      sync3 <= sync2;
      filt  <= next_filt;
    end
  end

  // ----------------------------------------------------------------
  // Combined clocks and their rising edges
  // ----------------------------------------------------------------
  logic [`NUM_REGS-1:0] comb_clk;
  logic [`NUM_REGS-1:0] clk_prev;
  logic [`NUM_REGS-1:0] next_clk_prev;
  logic [`NUM_REGS-1:0] rise;
  logic [`NUM_REGS-1:0] serial_bit;

  always_comb begin
    for (int i = 0; i < `NUM_REGS; i++) begin
      comb_clk[i]   = filt.shift_pulse_common | filt.shift_pulse_sep[i];
      // Only a low-to-high change shifts; a held-high clock blocks the other
      rise[i]       = comb_clk[i] & ~clk_prev[i];
      serial_bit[i] = pick_bit(filt.select,
                               filt.serial_in_first[i],
                               filt.serial_in_second[i]);
    end
    next_clk_prev = comb_clk;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      clk_prev <= `CLK_RESET;
    end else begin
      clk_prev <= next_clk_prev;
    end
  end

  // ----------------------------------------------------------------
  // Clear release synchroniser
  // ----------------------------------------------------------------
  // The clear still acts at once through the async reset of these flops,
  // but its release reaches the stages only on an mclk edge, so a release
  // that lands near a shift cannot leave a register half cleared.
  logic       clr_raw_n;
  logic [1:0] clr_sync;
  logic [1:0] next_clr_sync;

  assign clr_raw_n = rstn & clear_all_n;

  always_comb begin
    next_clr_sync = {clr_sync[0], 1'b1};
  end

  always_ff @(posedge mclk or negedge clr_raw_n) begin
    if (!clr_raw_n) begin
      clr_sync <= `CLR_SYNC_RESET;
    end else begin
      clr_sync <= next_clr_sync;
    end
  end

  // Only the second flop is read; the first may still be settling
  assign clr_n = clr_sync[1];

  // ----------------------------------------------------------------
  // Shift stages
  // ----------------------------------------------------------------
  stage_t stage      [`NUM_REGS];
  stage_t next_stage [`NUM_REGS];

  always_comb begin
    for (int i = 0; i < `NUM_REGS; i++) begin
      next_stage[i] = stage[i];
      if (rise[i]) begin
        // Whole register moves one place; the new bit is the value seen
        // at the rising edge, so later data changes cannot reach it
        next_stage[i] = {stage[i][`NUM_STAGES-2:0], serial_bit[i]};
      end
    end
  end

  always_ff @(posedge mclk or negedge clr_n) begin
    if (!clr_n) begin
      for (int i = 0; i < `NUM_REGS; i++) begin
        stage[i] <= `STAGE_RESET;
      end
    end else begin
      for (int i = 0; i < `NUM_REGS; i++) begin
        stage[i] <= next_stage[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < `NUM_REGS; i++) begin
      last_stage_out[i]     = stage[i][`NUM_STAGES-1];
      last_stage_out_inv[i] = ~stage[i][`NUM_STAGES-1];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  shift_on_rise_a: assert property (
    rise[0] |=> stage[0] == {$past(stage[0][6:0]), $past(serial_bit[0])})
    else $error("register 0 did not shift one place on a clock rise");

  capture_data_a: assert property (
    rise[1] |=> stage[1][0] == $past(serial_bit[1]))
    else $error("register 1 did not capture the serial bit at the rise");

  hold_freeze_a: assert property (
    (comb_clk[0] && clk_prev[0]) |=> $stable(stage[0]))
    else $error("register 0 changed while its clock was held high");

  fall_quiet_a: assert property (
    (!comb_clk[1] && clk_prev[1]) |=> $stable(last_stage_out[1]))
    else $error("output changed on a falling combined clock");

  common_inhibit_a: assert property (
    (filt.shift_pulse_common && $past(filt.shift_pulse_common)) |-> rise == 2'h0)
    else $error("shift occurred while the common clock stayed high");

  select_second_a: assert property (
    (rise[0] && filt.select) |=> stage[0][0] == $past(filt.serial_in_second[0]))
    else $error("select high did not take the second input");

  independent_a: assert property (
    (rise[0] && !rise[1]) |=> $stable(stage[1]))
    else $error("register 1 moved on register 0 clock only");

  last_stage_a: assert property (
    rise[1] |=> last_stage_out[1] == $past(stage[1][6]))
    else $error("last stage did not take stage seven on a rise");

  inverse_out_a: assert property (
    last_stage_out_inv == ~last_stage_out)
    else $error("inverted output does not mirror last stage");

  clear_empty_a: assert property (@(posedge mclk) disable iff (!rstn)
    !clear_all_n |-> (stage[0] == `STAGE_RESET && stage[1] == `STAGE_RESET))
    else $error("clear low did not empty both registers");

  select_first_a: assert property (
    (rise[1] && !filt.select) |=> stage[1][0] == $past(filt.serial_in_first[1]))
    else $error("select low did not take the first input");

  hold_freeze_one_a: assert property (
    (comb_clk[1] && clk_prev[1]) |=> $stable(stage[1]))
    else $error("register 1 changed while its clock was held high");

  fall_quiet_zero_a: assert property (
    (!comb_clk[0] && clk_prev[0]) |=> $stable(last_stage_out[0]))
    else $error("register 0 output changed on a falling combined clock");

  independent_one_a: assert property (
    (rise[1] && !rise[0]) |=> $stable(stage[0]))
    else $error("register 0 moved on register 1 clock only");

  rise_only_a: assert property (
    !rise[0] |=> $stable(stage[0]))
    else $error("register 0 changed without a combined clock rise");

  shift_one_c:   cover property (rise[0] && serial_bit[0]);
  shift_both_c:  cover property (rise == 2'h3);
  inhibit_c:     cover property (filt.shift_pulse_sep[1] && rise[0] && !rise[1]);
  select_c:      cover property (rise[0] && filt.select);
  clear_c:       cover property (@(posedge mclk) disable iff (!rstn)
                                 $fell(clear_all_n) && $past(stage[0]) != `STAGE_RESET);

endmodule

//--- dv/upstream_model.sv
/*
  Upstream logic model: drives select, serial data and both clock kinds.
  Assumes the bench calls its tasks from one process, at mclk edges.
*/
`timescale 1ns/1ps

module upstream_model (
  input  wire logic               mclk,
  output dual_shift_pkg::pin_in_t pins
);
  import dual_shift_pkg::*;

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  logic [1:0] held = 2'h0;

  initial pins = '0;

  // Data settles well ahead of the clock rise, past the pin synchroniser
  task automatic put_data(input logic       sel,
                          input logic [1:0] dat_first,
                          input logic [1:0] dat_second);
    @(posedge mclk);
    pins.select           <= sel;
    pins.serial_in_first  <= dat_first;
    pins.serial_in_second <= dat_second;
    repeat (4) @(posedge mclk);
  endtask

  // Held separate clocks stay high through the pulse
  task automatic pulse(input logic com, input logic [1:0] sep);
    @(posedge mclk);
    pins.shift_pulse_common <= com;
    pins.shift_pulse_sep    <= sep | held;
    repeat (4) @(posedge mclk);
    pins.shift_pulse_common <= 1'b0;
    pins.shift_pulse_sep    <= held;
    repeat (7) @(posedge mclk);
  endtask

  // A separate clock held high inhibits its register
  task automatic hold(input logic [1:0] h);
    held = h;
    @(posedge mclk);
    pins.shift_pulse_sep <= h;
    repeat (7) @(posedge mclk);
  endtask
endmodule

//--- dv/testbench.sv
/*
  Self-checking bench for the dual serial shift register.
  Assumes the upstream model drives every pin of the pin group.
*/
`timescale 1ns/1ps

module testbench;
  import dual_shift_pkg::*;

  // ----------------------------------------
  // Harness
  // ----------------------------------------
  logic       mclk        = 1'b0;
  logic       rstn        = 1'b0;
  logic       clear_all_n = 1'b1;
  pin_in_t    pins;
  logic [1:0] q;
  logic [1:0] qn;
  int         mismatches  = 0;
  int         tests_run   = 0;
  int         cycles      = 0;

  always #5 mclk = ~mclk;

  upstream_model up (.mclk(mclk), .pins(pins));

  dual_serial_shift_register DUT (
    .mclk               (mclk),
    .rstn               (rstn),
    .pins               (pins),
    .clear_all_n        (clear_all_n),
    .last_stage_out     (q),
    .last_stage_out_inv (qn)
  );

  task automatic check_out(input string what, input logic [1:0] exp);
    #1;
    tests_run++;
    if (q !== exp || qn !== ~exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h inv %h", what, exp, q, qn);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Lone one, then zeros, through each selector side; unselected side inverse
  task automatic shift_through;
    logic [1:0] d;
    for (int s = 0; s < 2; s++) begin
      for (int k = 1; k <= 8; k++) begin
        d = (k == 1) ? 2'h3 : 2'h0;
        up.put_data(s[0], s ? ~d : d, s ? d : ~d);
        up.pulse(1'b1, 2'h0);
        check_out("shift", (k == 8) ? 2'h3 : 2'h0);
      end
    end
  endtask

  // Raising a held clock shifts once; common pulses then miss that register
  task automatic inhibit;
    up.put_data(1'b0, 2'h3, 2'h0);
    up.hold(2'h2);
    check_out("separate", 2'h1);
    up.pulse(1'b1, 2'h0);
    check_out("inhibit", 2'h0);
    up.hold(2'h0);
    check_out("fall", 2'h0);
    // Both now hold one lone one; equal arrival proves no extra shift
    up.put_data(1'b0, 2'h0, 2'h3);
    for (int k = 1; k <= 7; k++) begin
      up.pulse(1'b1, 2'h0);
      check_out("count", (k == 7) ? 2'h3 : 2'h0);
    end
  endtask

  task automatic fill_and_clear;
    up.put_data(1'b0, 2'h3, 2'h0);
    for (int k = 1; k <= 8; k++) begin
      up.pulse(1'b0, 2'h1);
      check_out("fill", {1'b1, k == 8});
    end
    @(posedge mclk);
    clear_all_n <= 1'b0;
    check_out("clear", 2'h0);
    repeat (3) @(posedge mclk);
    clear_all_n <= 1'b1;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      complete_run();
    end
  end

  initial begin
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    check_out("reset", 2'h0);
    shift_through();
    inhibit();
    fill_and_clear();
    complete_run();
  end
endmodule
